// file: pcec_pkg.sv
// constants and carrier types of the power controller event counting block
package pcec_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTL0 = 8'h00;
	localparam logic [7:0] OFS_CTR0 = 8'h10;
	localparam logic [7:0] OFS_FILT = 8'h30;
	// control field positions
	localparam int CTL_EDGE  = 18;
	localparam int CTL_EN    = 22;
	localparam int CTL_INV   = 23;
	localparam int THR_LSB   = 24;
	localparam int CTL_OINV  = 30;
	localparam int CTL_OEDGE = 31;
	// reset values
	localparam logic [31:0] CTL_RST  = 32'h0;
	localparam logic [31:0] FILT_RST = 32'h0;
	localparam logic [47:0] CTR_RST  = 48'h0;
	// band filter step in MHz
	localparam int BAND_STEP_MHZ = 100;
	// event codes
	localparam logic [7:0] EV_CLK     = 8'h00;
	localparam logic [7:0] EV_VOLT    = 8'h03;
	localparam logic [7:0] EV_THERM   = 8'h04;
	localparam logic [7:0] EV_PWR     = 8'h05;
	localparam logic [7:0] EV_PMAX    = 8'h06;
	localparam logic [7:0] EV_HOTI    = 8'h09;
	localparam logic [7:0] EV_HOTO    = 8'h0a;
	localparam logic [7:0] EV_BAND0   = 8'h0b;
	localparam logic [7:0] EV_BAND3   = 8'h0e;
	localparam logic [7:0] EV_PKG0    = 8'h2a;
	localparam logic [7:0] EV_PKG2E   = 8'h2b;
	localparam logic [7:0] EV_PKG3    = 8'h2c;
	localparam logic [7:0] EV_PKG6    = 8'h2d;
	localparam logic [7:0] EV_MEMSHED = 8'h2f;
	localparam logic [7:0] EV_DEMOTE  = 8'h30;
	localparam logic [7:0] EV_VRHOT   = 8'h42;
	localparam logic [7:0] EV_CLIPA   = 8'h49;
	localparam logic [7:0] EV_CLIPB   = 8'h4a;
	localparam logic [7:0] EV_TOTTR   = 8'h72;
	localparam logic [7:0] EV_IOFLOOR = 8'h73;
	localparam logic [7:0] EV_FREQCHG = 8'h74;
	localparam logic [7:0] EV_SHED0   = 8'h75;
	localparam logic [7:0] EV_SHED3   = 8'h78;
	localparam logic [7:0] EV_OCC     = 8'h80;
	// occupancy unit masks
	localparam logic [7:0] UM_ACTIVE = 8'h40;
	localparam logic [7:0] UM_SLEEP3 = 8'h80;
	localparam logic [7:0] UM_SLEEP6 = 8'hc0;
	// package state encoding
	localparam logic [1:0] PKG_C0  = 2'h0;
	localparam logic [1:0] PKG_C2E = 2'h1;
	localparam logic [1:0] PKG_C3  = 2'h2;
	localparam logic [1:0] PKG_C6  = 2'h3;

	// event signals from the microcontroller and hardware
	typedef struct packed {
		logic       thermalLimit;
		logic       powerLimit;
		logic       hotInternal;
		logic       hotExternal;
		logic       memShed;
		logic       regulatorHot;
		logic       coreTransition;
		logic       ioFloor;
		logic       freqChange;
		logic       voltTransition;
		logic       stateDemotion;
		logic       pkgTransit;
		logic [1:0] pkgState;
		logic [1:0] shedState;
		logic [3:0] activeCores;
		logic [3:0] sleep3Cores;
		logic [3:0] sleep6Cores;
		logic [7:0] freqRatio;
	} pcec_evt_t;

	typedef struct packed {
		logic [3:0][31:0] ctl;
		logic [3:0][47:0] ctr;
		logic [31:0]      filt;
		logic [3:0]       prevHit;
		logic [31:0]      prdata;
		logic             pready;
		logic             pslverr;
	} pcec_state_t;
endpackage

// file: pcec_top.sv
// four-counter event selection and counting logic with apb register access
// Notes on behaviour
// - three 4-bit core counts, active, sleep3 and sleep6, read every cycle
// - clocktick event 0x00 adds one per enabled cycle
// - codes 0x2a..0x2d count package residency, transit cycles excluded
// - edge detect counts state entries; with invert it counts exits
// - occupancy event 0x80 adds selected core count, up to 8, any counter
// - unit mask 0x40 active, 0x80 sleep3, 0xc0 sleep6 cores
// - code 0x74 counts frequency change cycles, no thread filter
// - code 0x04 counts cycles of thermal frequency reduction
// - code 0x05 counts cycles power bounds the frequency
// - code 0x73 counts cycles the io floor blocks lowering frequency
// - code 0x2f counts memory phase shedding cycles
// - codes 0x09 and 0x0a count internal and external hot throttle cycles
// - code 0x42 counts core supply regulator over-temperature cycles
// - code 0x72 counts core c-state transition cycles of all cores
// - codes 0x75..0x78 count integrated regulator shed states 0..3
// - occupancy with threshold 5 counts cycles with more than four active
// - adding edge detect counts only the first cycle of that condition
// - code 0x03 counts voltage transition cycles
// - band filter values are frequency ratios in 100 MHz steps
// - bit 31 edge detects occupancy after a nonzero threshold compare
// - bit 30 turns the compare into less-than, edges become falling
`timescale 1ns/1ns
module pcec_top (
	input  wire logic               ref_clk,
	input  wire logic               rst_n,
	input  wire logic               clk_en,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	input  wire pcec_pkg::pcec_evt_t evt,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr
);
	logic [1:0]            rstSync;
	logic                  rstQ;
	pcec_pkg::pcec_state_t st_q;
	pcec_pkg::pcec_state_t st_d;
	logic [3:0][47:0]      ctrNext;
	logic [3:0]            hitNext;
	logic                  busAcc;
	logic                  busWr;

	// reset release through two flops, assertion stays asynchronous
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rstSync <= 2'h0;
		else
			rstSync <= {rstSync[0], 1'b1};
	end
	assign rstQ = rstSync[1];

	// an access completes only in the cycle pready is shown
	assign busAcc = psel && penable && st_q.pready;
	assign busWr  = busAcc && pwrite;

	// per counter event selection and increment
	for (genvar i = 0; i < 4; i++)
	begin : g_cnt
		logic [7:0] ev;
		logic [7:0] umask;
		logic [5:0] thr;
		logic [3:0] raw;
		logic [3:0] inc;
		logic [1:0] bandIdx;
		logic       cmp;
		logic       bit0;
		logic       hit;
		assign ev      = st_q.ctl[i][7:0];
		assign umask   = st_q.ctl[i][15:8];
		assign thr     = st_q.ctl[i][pcec_pkg::THR_LSB +: 6];
		assign bandIdx = 2'(ev - pcec_pkg::EV_BAND0);

		// raw event value, zero for codes without a source
		always_comb
		begin
			raw = 4'h0;
			if (ev >= pcec_pkg::EV_BAND0 && ev <= pcec_pkg::EV_BAND3)
				raw = {3'h0, evt.freqRatio < st_q.filt[bandIdx*8 +: 8]};
			else if (ev >= pcec_pkg::EV_SHED0 && ev <= pcec_pkg::EV_SHED3)
				raw = {3'h0, evt.shedState == 2'(ev - pcec_pkg::EV_SHED0)};
			else
			begin
				case (ev)
					pcec_pkg::EV_CLK:     raw = 4'h1;
					pcec_pkg::EV_VOLT:    raw = {3'h0, evt.voltTransition};
					pcec_pkg::EV_THERM:   raw = {3'h0, evt.thermalLimit};
					pcec_pkg::EV_PWR:     raw = {3'h0, evt.powerLimit};
					pcec_pkg::EV_HOTI:    raw = {3'h0, evt.hotInternal};
					pcec_pkg::EV_HOTO:    raw = {3'h0, evt.hotExternal};
					pcec_pkg::EV_PKG0:
						raw = {3'h0, evt.pkgState == pcec_pkg::PKG_C0 && !evt.pkgTransit};
					pcec_pkg::EV_PKG2E:
						raw = {3'h0, evt.pkgState == pcec_pkg::PKG_C2E && !evt.pkgTransit};
					pcec_pkg::EV_PKG3:
						raw = {3'h0, evt.pkgState == pcec_pkg::PKG_C3 && !evt.pkgTransit};
					pcec_pkg::EV_PKG6:
						raw = {3'h0, evt.pkgState == pcec_pkg::PKG_C6 && !evt.pkgTransit};
					pcec_pkg::EV_MEMSHED: raw = {3'h0, evt.memShed};
					pcec_pkg::EV_DEMOTE:  raw = {3'h0, evt.stateDemotion};
					pcec_pkg::EV_VRHOT:   raw = {3'h0, evt.regulatorHot};
					pcec_pkg::EV_TOTTR:   raw = {3'h0, evt.coreTransition};
					pcec_pkg::EV_IOFLOOR: raw = {3'h0, evt.ioFloor};
					pcec_pkg::EV_FREQCHG: raw = {3'h0, evt.freqChange};
					pcec_pkg::EV_OCC:
					begin
						// mask picks one of the core count sources
						case (umask)
							pcec_pkg::UM_ACTIVE: raw = evt.activeCores;
							pcec_pkg::UM_SLEEP3: raw = evt.sleep3Cores;
							pcec_pkg::UM_SLEEP6: raw = evt.sleep6Cores;
							default:             raw = 4'h0;
						endcase
					end
					// 0x06, 0x49, 0x4a fall here and never count
					default: raw = 4'h0;
				endcase
			end
		end

		// threshold, inversion and edge filtering
		always_comb
		begin
			cmp  = 1'b0;
			bit0 = 1'b0;
			hit  = 1'b0;
			inc  = 4'h0;
			if (ev[7])
			begin
				// compare first, edge after it, so a zero threshold bypasses both
				if (st_q.ctl[i][pcec_pkg::CTL_OINV])
					cmp = {2'h0, raw} < thr;
				else
					cmp = {2'h0, raw} >= thr;
				hit = cmp;
				if (thr == 6'h0)
					inc = raw;
				else if (st_q.ctl[i][pcec_pkg::CTL_OEDGE])
					inc = {3'h0, cmp && !st_q.prevHit[i]};
				else
					inc = {3'h0, cmp};
			end
			else
			begin
				bit0 = raw[0] ^ st_q.ctl[i][pcec_pkg::CTL_INV];
				hit  = bit0;
				if (st_q.ctl[i][pcec_pkg::CTL_EDGE])
					inc = {3'h0, bit0 && !st_q.prevHit[i]};
				else
					inc = {3'h0, bit0};
			end
			if (!st_q.ctl[i][pcec_pkg::CTL_EN])
				inc = 4'h0;
		end

		// edge history follows the filtered level even while disabled
		assign hitNext[i] = hit;
		assign ctrNext[i] = st_q.ctr[i] + {44'h0, inc};
	end

	// register file, bus answer and counter advance
	always_comb
	begin
		st_d         = st_q;
		st_d.pready  = 1'b0;
		st_d.ctr     = ctrNext;
		st_d.prevHit = hitNext;
		// setup cycle: decode and latch read data, answer next cycle
		if (psel && !penable && !st_q.pready)
		begin
			st_d.pready  = 1'b1;
			st_d.pslverr = 1'b1;
			st_d.prdata  = 32'h0;
			for (int i = 0; i < 4; i++)
			begin
				if (paddr == pcec_pkg::OFS_CTL0 + 8'(4 * i))
				begin
					st_d.pslverr = 1'b0;
					st_d.prdata  = st_q.ctl[i];
				end
				if (paddr == pcec_pkg::OFS_CTR0 + 8'(8 * i))
				begin
					st_d.pslverr = 1'b0;
					st_d.prdata  = st_q.ctr[i][31:0];
				end
				if (paddr == pcec_pkg::OFS_CTR0 + 8'(8 * i + 4))
				begin
					st_d.pslverr = 1'b0;
					st_d.prdata  = {16'h0, st_q.ctr[i][47:32]};
				end
			end
			if (paddr == pcec_pkg::OFS_FILT)
			begin
				st_d.pslverr = 1'b0;
				st_d.prdata  = st_q.filt;
			end
		end
		// write takes effect at the completing edge, over any increment
		if (busWr)
		begin
			for (int i = 0; i < 4; i++)
			begin
				if (paddr == pcec_pkg::OFS_CTL0 + 8'(4 * i))
					st_d.ctl[i] = pwdata;
				if (paddr == pcec_pkg::OFS_CTR0 + 8'(8 * i))
					st_d.ctr[i][31:0] = pwdata;
				if (paddr == pcec_pkg::OFS_CTR0 + 8'(8 * i + 4))
					st_d.ctr[i][47:32] = pwdata[15:0];
			end
			if (paddr == pcec_pkg::OFS_FILT)
				st_d.filt = pwdata;
		end
	end

	// single state register, frozen while the clock enable is low
	always_ff @(posedge ref_clk or negedge rstQ)
	begin
		if (!rstQ)
		begin
			st_q.ctl     <= {4{pcec_pkg::CTL_RST}};
			st_q.ctr     <= {4{pcec_pkg::CTR_RST}};
			st_q.filt    <= pcec_pkg::FILT_RST;
			st_q.prevHit <= 4'h0;
			st_q.prdata  <= 32'h0;
			st_q.pready  <= 1'b0;
			st_q.pslverr <= 1'b0;
		end
		else if (clk_en)
			st_q <= st_d;
	end

	assign prdata  = st_q.prdata;
	assign pready  = st_q.pready;
	assign pslverr = st_q.pslverr;

	// checks on counter 0, the counting ones taken only in cycles with no bus write
	logic       run0;
	logic [7:0] ev0;
	logic [5:0] thr0;
	logic       plain0;
	assign run0   = clk_en && st_q.ctl[0][pcec_pkg::CTL_EN] && !busWr;
	assign ev0    = st_q.ctl[0][7:0];
	assign thr0   = st_q.ctl[0][pcec_pkg::THR_LSB +: 6];
	assign plain0 = !st_q.ctl[0][pcec_pkg::CTL_INV] && !st_q.ctl[0][pcec_pkg::CTL_EDGE]
		&& !st_q.ctl[0][pcec_pkg::CTL_OINV] && !st_q.ctl[0][pcec_pkg::CTL_OEDGE];

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstQ);

	property p_clk;
		run0 && ev0 == pcec_pkg::EV_CLK && plain0
		|=> st_q.ctr[0] == $past(st_q.ctr[0]) + 48'h1;
	endproperty
	a_clk: assert property (p_clk)
		else $error("clocktick count did not add one");

	property p_dead;
		clk_en && !busWr && (ev0 == pcec_pkg::EV_PMAX || ev0 == pcec_pkg::EV_CLIPA
			|| ev0 == pcec_pkg::EV_CLIPB)
		|=> $stable(st_q.ctr[0]);
	endproperty
	a_dead: assert property (p_dead)
		else $error("unsourced event advanced a counter");

	property p_occ;
		run0 && ev0 == pcec_pkg::EV_OCC && st_q.ctl[0][15:8] == pcec_pkg::UM_ACTIVE
			&& thr0 == 6'h0
		|=> st_q.ctr[0] == $past(st_q.ctr[0]) + {44'h0, $past(evt.activeCores)};
	endproperty
	a_occ: assert property (p_occ)
		else $error("occupancy did not add active core count");

	property p_thr;
		run0 && ev0 == pcec_pkg::EV_OCC && st_q.ctl[0][15:8] == pcec_pkg::UM_ACTIVE
			&& thr0 == 6'h5 && plain0
		|=> st_q.ctr[0] == $past(st_q.ctr[0]) + {47'h0, $past(evt.activeCores) > 4'h4};
	endproperty
	a_thr: assert property (p_thr)
		else $error("threshold five count wrong");

	property p_edge;
		run0 && ev0 == pcec_pkg::EV_OCC && thr0 != 6'h0
			&& st_q.ctl[0][pcec_pkg::CTL_OEDGE] && st_q.prevHit[0]
		|=> $stable(st_q.ctr[0]);
	endproperty
	a_edge: assert property (p_edge)
		else $error("edge detect counted a held condition");

	property p_inv;
		run0 && ev0 == pcec_pkg::EV_OCC && st_q.ctl[0][15:8] == pcec_pkg::UM_ACTIVE
			&& thr0 == 6'h4 && st_q.ctl[0][pcec_pkg::CTL_OINV]
			&& !st_q.ctl[0][pcec_pkg::CTL_OEDGE] && evt.activeCores < 4'h4
		|=> st_q.ctr[0] == $past(st_q.ctr[0]) + 48'h1;
	endproperty
	a_inv: assert property (p_inv)
		else $error("inverted compare missed a cycle");

	property p_pkg;
		run0 && ev0 == pcec_pkg::EV_PKG0 && plain0
		|=> st_q.ctr[0] == $past(st_q.ctr[0])
			+ {47'h0, $past(evt.pkgState) == pcec_pkg::PKG_C0 && !$past(evt.pkgTransit)};
	endproperty
	a_pkg: assert property (p_pkg)
		else $error("package residency count wrong");

	property p_exit;
		run0 && ev0 == pcec_pkg::EV_PKG0 && st_q.ctl[0][pcec_pkg::CTL_EDGE]
			&& st_q.ctl[0][pcec_pkg::CTL_INV] && (evt.pkgState == pcec_pkg::PKG_C0)
			&& !evt.pkgTransit
		|=> $stable(st_q.ctr[0]);
	endproperty
	a_exit: assert property (p_exit)
		else $error("exit count advanced while resident");

	property p_therm;
		run0 && ev0 == pcec_pkg::EV_THERM && plain0 && !evt.thermalLimit
		|=> $stable(st_q.ctr[0]);
	endproperty
	a_therm: assert property (p_therm)
		else $error("thermal count advanced without throttling");

	property p_hot;
		run0 && ev0 == pcec_pkg::EV_HOTI && plain0 && evt.hotInternal
		|=> st_q.ctr[0] == $past(st_q.ctr[0]) + 48'h1;
	endproperty
	a_hot: assert property (p_hot)
		else $error("internal hot cycle not counted");

	// band 0 compares the ratio with filter byte 0, a shed code with its level
	property p_band;
		run0 && ev0 == pcec_pkg::EV_BAND0 && plain0
		|=> st_q.ctr[0] == $past(st_q.ctr[0])
			+ {47'h0, $past(evt.freqRatio) < $past(st_q.filt[7:0])};
	endproperty
	a_band: assert property (p_band)
		else $error("band count wrong");

	property p_shed;
		run0 && ev0 == pcec_pkg::EV_SHED0 && plain0
		|=> st_q.ctr[0] == $past(st_q.ctr[0]) + {47'h0, $past(evt.shedState) == 2'h0};
	endproperty
	a_shed: assert property (p_shed)
		else $error("shed state count wrong");

	property p_dis;
		clk_en && !busWr && !st_q.ctl[0][pcec_pkg::CTL_EN]
		|=> $stable(st_q.ctr[0]);
	endproperty
	a_dis: assert property (p_dis)
		else $error("disabled counter advanced");

	// a low enable must hold the count and the bus answer alike
	property p_frz;
		!clk_en
		|=> $stable(st_q.ctr[0]) && $stable(st_q.pready);
	endproperty
	a_frz: assert property (p_frz)
		else $error("state moved while clock enable low");

	property p_ctlwr;
		busWr && clk_en && paddr == pcec_pkg::OFS_CTL0
		|=> st_q.ctl[0] == $past(pwdata);
	endproperty
	a_ctlwr: assert property (p_ctlwr)
		else $error("control write did not land");

	// a frozen second cycle keeps pready up, so it is excused there
	property p_ready;
		psel && !penable && !st_q.pready && clk_en
		|=> st_q.pready ##1 (!st_q.pready || !$past(clk_en));
	endproperty
	a_ready: assert property (p_ready)
		else $error("pready not a single cycle after setup");
endmodule // pcec_top

// file: pcec_evt_model.sv
// event source model standing in for the power microcontroller and hardware
`timescale 1ns/1ns
module pcec_evt_model (
	input  wire logic          ref_clk,
	input  wire logic [31:0]   rnd,
	output pcec_pkg::pcec_evt_t evt
);
	logic [3:0] active;
	logic [3:0] nap3;
	logic [3:0] nap6;

	// at most eight cores per count, so the occupancy add stays in range
	assign active = 4'(rnd[19:16] % 4'h9); // core cap
	assign nap3   = 4'(rnd[23:20] % 4'h9); // core cap
	assign nap6   = 4'(rnd[27:24] % 4'h9); // core cap

	initial evt = '0;

	// fresh levels just after every edge, as a registered source would give
	always @(posedge ref_clk)
		evt <= {rnd[11:0], rnd[15:12], active, nap3, nap6, rnd[31:24]}; // 4-bit counts
endmodule // pcec_evt_model

// file: testbench.sv
// self-checking bench of the event counting block against a cycle model
`timescale 1ns/1ns
`define CHK(NM, E, G) \
	begin checks++; if ((G) !== (E)) begin errorCnt++; \
	$display("unexpected %s exp %h got %h", NM, E, G); end end
module testbench;
	logic                ref_clk = 1'b0;
	logic                rst_n   = 1'b0;
	logic                clk_en  = 1'b1;
	logic                psel    = 1'b0;
	logic                penable = 1'b0;
	logic                pwrite  = 1'b0;
	logic [7:0]          paddr   = 8'h00;
	logic [31:0]         pwdata  = 32'h0;
	logic [31:0]         rnd     = 32'h0;
	pcec_pkg::pcec_evt_t evt;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	int                  errorCnt = 0;
	int                  checks   = 0;
	int                  cyc      = 0;
	logic [31:0]         mCtl [4] = '{default: pcec_pkg::CTL_RST};
	logic [47:0]         mCtr [4] = '{default: pcec_pkg::CTR_RST};
	logic [31:0]         mFilt    = pcec_pkg::FILT_RST;
	logic [3:0]          mPrev    = 4'h0;
	logic [31:0]         mSnap    = 32'h0;
	logic [31:0]         cfg [48];
	// counter 0 gets band 0, dead, thermal, hot, residency and shed codes
	logic [7:0]          codes [28] = '{8'h0b, 8'h03, 8'h00, 8'h05, 8'h06, 8'h0a, 8'h0c,
		8'h0d, 8'h04, 8'h0e, 8'h2b, 8'h2c, 8'h09, 8'h2d, 8'h2f, 8'h30, 8'h2a, 8'h42,
		8'h49, 8'h4a, 8'h60, 8'h72, 8'h73, 8'h74, 8'h75, 8'h76, 8'h77, 8'h78};
	// exits and entries, pairs of cases 5 and 6, edges, accumulate
	logic [31:0]         extra [20] = '{32'h00c4_002a, 32'h0044_002d, 32'h00c0_0004,
		32'h0040_8080, 32'h0540_4080, 32'h0040_0003, 32'h0040_4080, 32'h0040_c080,
		32'h44c0_4080, 32'h0040_000b, 32'hc440_4080, 32'h0140_8080, 32'h8540_4080,
		32'h0044_0074, 32'h0000_0000, 32'h0040_c080, 32'h0040_4080, 32'h00c0_0005,
		32'h0040_000e, 32'h0140_4080};

	pcec_top pcec_top_inst (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clk_en  (clk_en),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.evt     (evt),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr)
	);

	pcec_evt_model pcec_evt_model_inst (
		.ref_clk (ref_clk),
		.rnd     (rnd),
		.evt     (evt)
	);

	always #10 ref_clk = ~ref_clk;

	// one seeded source feeds every random value the bench uses
	initial
	begin
		void'($urandom(57));
		forever
			@(posedge ref_clk) rnd <= $urandom;
	end

	// hang guard well above the planned run length
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			errorCnt++;
			test_done();
		end
	end

	function automatic logic isBad(input logic [7:0] a);
		return a[1:0] != 2'h0 || a > pcec_pkg::OFS_FILT;
	endfunction

	function automatic logic rawEv(input logic [7:0] ev);
		case (ev)
			8'h00: return 1'b1;
			8'h03: return evt.voltTransition;
			8'h04: return evt.thermalLimit;
			8'h05: return evt.powerLimit;
			8'h09: return evt.hotInternal;
			8'h0a: return evt.hotExternal;
			8'h0b, 8'h0c, 8'h0d, 8'h0e: return evt.freqRatio < mFilt[8 * (ev - 8'h0b) +: 8];
			8'h2a, 8'h2b, 8'h2c, 8'h2d: return !evt.pkgTransit && ev == 8'h2a + 8'(evt.pkgState);
			8'h2f: return evt.memShed;
			8'h30: return evt.stateDemotion;
			8'h42: return evt.regulatorHot;
			8'h72: return evt.coreTransition;
			8'h73: return evt.ioFloor;
			8'h74: return evt.freqChange;
			8'h75, 8'h76, 8'h77, 8'h78: return ev == 8'h75 + 8'(evt.shedState);
			default: return 1'b0; // never counts
		endcase
	endfunction

	function automatic logic [31:0] expRead(input logic [7:0] a);
		logic [1:0] i;
		i = 2'((a - 8'h10) >> 3);
		if (isBad(a))
			return 32'h0;
		if (a == pcec_pkg::OFS_FILT)
			return mFilt;
		if (a < pcec_pkg::OFS_CTR0)
			return mCtl[a[3:2]];
		return a[2] ? {16'h0, mCtr[i][47:32]} : mCtr[i][31:0];
	endfunction

	// read snapshot at setup, counts, then a bus write wins
	always @(posedge ref_clk)
	begin : cycleModel
		logic [31:0] c;
		logic [1:0]  i;
		int          v;
		int          inc;
		logic        h;
		if (clk_en)
		begin
			if (psel && !penable)
				mSnap = expRead(paddr);
			for (int n = 0; n < 4; n++)
			begin
				c = mCtl[n];
				v = c[15:8] == 8'h40 ? evt.activeCores : c[15:8] == 8'h80 ? evt.sleep3Cores
					: c[15:8] == 8'hc0 ? evt.sleep6Cores : 0; // mask choice
				h = c[7] ? (c[30] ? v < c[29:24] : v >= c[29:24]) : rawEv(c[7:0]) ^ c[23];
				inc = (c[7] ? c[31] : c[18]) ? h && !mPrev[n] : h; // edge
				if (c[7] && c[29:24] == 6'h0)
					inc = v; // raw add
				if (c[22])
					mCtr[n] += 48'(inc);
				mPrev[n] = h;
			end
			i = 2'((paddr - 8'h10) >> 3);
			if (psel && penable && pwrite && !isBad(paddr))
			begin
				if (paddr == pcec_pkg::OFS_FILT)
					mFilt = pwdata;
				else if (paddr < pcec_pkg::OFS_CTR0)
					mCtl[paddr[3:2]] = pwdata;
				else if (paddr[2])
					mCtr[i][47:32] = pwdata[15:0];
				else
					mCtr[i][31:0] = pwdata;
			end
		end
	end

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic [31:0] ex);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do
			@(posedge ref_clk) n++;
		while (pready !== 1'b1);
		rd = prdata;
		ex = mSnap;
		`CHK("access edges", 1, n) // zero wait states
		`CHK("pslverr", isBad(a), pslverr)
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, errorCnt);
		if (errorCnt == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// main sequence: reset values, counting groups, wrap, refusals
	initial
	begin
		logic [31:0] rd;
		logic [31:0] ex;
		logic [31:0] a [4];
		logic [31:0] sa [4];
		for (int i = 0; i < 28; i++)
			cfg[i] = 32'h0040_0000 | 32'(codes[i]);
		for (int i = 0; i < 20; i++)
			cfg[28 + i] = extra[i];
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		for (int r = 0; r <= 12; r++)
		begin
			apb(1'b0, 8'(4 * r), 32'h0, rd, ex);
			`CHK("reset value", ex, rd)
		end
		$display("reset values done");
		for (int g = 0; g < 12; g++)
		begin
			apb(1'b1, pcec_pkg::OFS_FILT, g == 9 ? 32'h14 : rnd, rd, ex); // 2.0 GHz band
			for (int n = 0; n < 4; n++)
			begin
				apb(1'b1, 8'(4 * n), cfg[4 * g + n], rd, ex);
				apb(1'b0, 8'(4 * n), 32'h0, rd, ex);
				`CHK("control", cfg[4 * g + n], rd) // own selection
			end
			for (int n = 0; n < 4; n++)
				apb(1'b0, 8'(8'h10 + 8 * n), 32'h0, a[n], sa[n]);
			repeat (30)
				@(posedge ref_clk) clk_en <= rnd[31:30] != 2'h0;
			@(posedge ref_clk) clk_en <= 1'b1;
			for (int n = 0; n < 4; n++)
			begin
				apb(1'b0, 8'(8'h10 + 8 * n), 32'h0, rd, ex);
				`CHK("count delta", ex - sa[n], rd - a[n])
			end
			$display("counting group %0d done", g);
		end
		apb(1'b1, pcec_pkg::OFS_CTL0, 32'h0040_0000, rd, ex);
		apb(1'b1, pcec_pkg::OFS_CTR0 + 8'h4, 32'h1234_abcd, rd, ex);
		apb(1'b1, pcec_pkg::OFS_CTR0, 32'hffff_fff0, rd, ex);
		repeat (20) @(posedge ref_clk);
		apb(1'b0, pcec_pkg::OFS_CTR0, 32'h0, rd, ex);
		`CHK("low half", ex, rd) // wall clock count
		apb(1'b0, pcec_pkg::OFS_CTR0 + 8'h4, 32'h0, rd, ex);
		`CHK("high half", ex, rd) // carry into the upper bits
		`CHK("high unused", 16'h0, rd[31:16])
		$display("wrap test done");
		apb(1'b0, 8'h34, 32'h0, rd, ex);
		`CHK("unmapped read", 32'h0, rd)
		apb(1'b0, 8'h02, 32'h0, rd, ex);
		`CHK("unaligned read", 32'h0, rd)
		apb(1'b1, 8'h38, rnd, rd, ex);
		apb(1'b0, pcec_pkg::OFS_FILT, 32'h0, rd, ex);
		`CHK("filter kept", ex, rd)
		$display("refusal test done");
		test_done();
	end
endmodule // testbench
